/* File: pkg/pbtc_map.vh */
`ifndef PBTC_MAP_VH
`define PBTC_MAP_VH
`define PBTC_REG_ADDR 5'h1b
`define PBTC_ERR_MSB 15
`define PBTC_ERR_LSB 8
`define PBTC_RSVD_HI 7
`define PBTC_RSVD_LO 6
`define PBTC_CONT_BIT 5
`define PBTC_PATEN_BIT 4
`define PBTC_RSVD_MID 3
`define PBTC_GAP_BIT 2
`define PBTC_SEL_MSB 1
`define PBTC_SEL_LSB 0
`define PBTC_SEL_DATA_A 2'h0
`define PBTC_SEL_DATA_B 2'h1
`define PBTC_SEL_LINK 2'h2
`define PBTC_SEL_TONE 2'h3
`define PBTC_ERR_MAX 8'hff
`define PBTC_GAP_LONG_NS 15000
`define PBTC_GAP_SHORT_NS 10000
`define PBTC_CLK_NS 10
`define PBTC_SEQ_CYCLES 16'h0064
`endif

/* File: verif/pbtc_ctrl_checker.sv */
`timescale 1ns/1ps
module pbtc_ctrl_checker (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire [4:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire selftest_run_i,
    input wire jabber_disable_i,
    input wire [15:0] reg_rdata_o,
    input wire reg_hit_o,
    input wire cont_prbs_tx_o,
    input wire no_ipg_o,
    input wire jabber_enable_o,
    input wire pattern_active_o,
    input wire [1:0] pattern_sel_o,
    input wire seq_data_a_o,
    input wire seq_data_b_o,
    input wire seq_link_o,
    input wire seq_tone_o
);
default clocking cb @(posedge core_clk_i); endclocking
default disable iff (!arst_n_i);
wire acc = (reg_wr_i || reg_rd_i) && reg_addr_i == 5'h1b;
wire [3:0] seqs = {seq_tone_o, seq_link_o, seq_data_b_o, seq_data_a_o};
a_hit_on_access: assert property (acc |=> reg_hit_o)
    else $error("access not acknowledged");
a_no_stray_hit: assert property (!acc |=> !reg_hit_o)
    else $error("hit without access");
a_rdata_hold: assert property
    (!$past(reg_rd_i && reg_addr_i == 5'h1b) |-> $stable(reg_rdata_o))
    else $error("read data moved without read");
a_jabber_follow: assert property
    (1 |=> jabber_enable_o == !$past(jabber_disable_i))
    else $error("jabber enable wrong");
a_cont_gated: assert property (cont_prbs_tx_o |-> $past(selftest_run_i))
    else $error("continuous tx without self-test");
a_ipg_match: assert property (no_ipg_o == cont_prbs_tx_o)
    else $error("gap removal differs from continuous tx");
a_seq_onehot: assert property
    (seqs == (pattern_active_o ? 4'h1 << pattern_sel_o : 4'h0))
    else $error("sequence outputs disagree with select");
a_gap_quiet: assert property
    ($fell(pattern_active_o) && pattern_sel_o != 2'h3
     |=> !pattern_active_o [*8])
    else $error("gap too short");
c_access: cover property (acc && reg_wr_i);
c_tone: cover property (seq_tone_o);
c_cont: cover property (cont_prbs_tx_o);
endmodule // pbtc_ctrl_checker

bind pbtc_ctrl pbtc_ctrl_checker chk (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .selftest_run_i(selftest_run_i), .jabber_disable_i(jabber_disable_i),
    .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .cont_prbs_tx_o(cont_prbs_tx_o), .no_ipg_o(no_ipg_o),
    .jabber_enable_o(jabber_enable_o), .pattern_active_o(pattern_active_o),
    .pattern_sel_o(pattern_sel_o), .seq_data_a_o(seq_data_a_o),
    .seq_data_b_o(seq_data_b_o), .seq_link_o(seq_link_o),
    .seq_tone_o(seq_tone_o)
);

/* File: verif/pbtc_host_model.sv */
`timescale 1ns/1ps
module pbtc_host_model (
    input wire cont_i,
    input wire [15:0] data_i,
    output wire [15:0] wdata_o,
    output wire jabber_disable_o
);
// reserved positions always go out as zero
assign wdata_o = data_i & 16'hff37;
// jabber off before any continuous run at 10 Mb/s
assign jabber_disable_o = cont_i;
endmodule // pbtc_host_model

/* File: verif/phy_packet_selftest_pattern_test_ctrl_bench.sv */
`timescale 1ns/1ps
module phy_packet_selftest_pattern_test_ctrl_bench;
reg clk = 0, rst_n = 0, wr = 0, rd = 0, start = 0, run = 0;
reg err = 0, mode = 0, cont = 0;
reg [4:0] addr = 5'h1b;
reg [15:0] data = 16'h0000;
wire [15:0] wdata, rdata;
wire jd, prbs, ipg, jab, act, fire, sa, sb, sl, st, hit;
wire [1:0] sel;
integer bad_count = 0, samples_checked = 0, i, iv;
pbtc_host_model host (.cont_i(cont), .data_i(data), .wdata_o(wdata),
    .jabber_disable_o(jd));
pbtc_ctrl uut (.core_clk_i(clk), .arst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .selftest_start_i(start), .selftest_run_i(run), .nibble_err_i(err),
    .jabber_disable_i(jd), .ten_meg_mode_i(mode),
    .seq_cycles_i(16'h000a), .reg_rdata_o(rdata), .reg_hit_o(hit),
    .cont_prbs_tx_o(prbs), .no_ipg_o(ipg), .jabber_enable_o(jab),
    .pattern_active_o(act), .pattern_sel_o(sel), .seq_data_a_o(sa),
    .seq_data_b_o(sb), .seq_link_o(sl), .seq_tone_o(st), .seq_fire_o(fire));
initial begin
    forever #5 clk = ~clk;
end
task chk(input [15:0] seen, input [15:0] exp);
    begin
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
endtask
task access(input w, input [4:0] a, input [15:0] d);
    begin
        @(negedge clk);
        addr = a;
        data = d;
        wr = w;
        rd = !w;
        @(negedge clk);
        chk(hit, a == 5'h1b);
        wr = 0;
        rd = 0;
    end
endtask
task errs(input integer k);
    begin
        @(negedge clk);
        err = 1;
        repeat (k) @(negedge clk);
        err = 0;
    end
endtask
// cycles from one sequence start to the next
task fire_gap;
    begin
        iv = 0;
        while (fire !== 1'b1 && iv < 4000) begin
            @(negedge clk);
            iv = iv + 1;
        end
        iv = 0;
        @(negedge clk);
        while (fire !== 1'b1 && iv < 4000) begin
            @(negedge clk);
            iv = iv + 1;
        end
    end
endtask
task end_of_test;
    begin
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
endtask
initial begin
    #200000;
    bad_count = bad_count + 1;
    end_of_test;
end
initial begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    access(0, 5'h1b, 0);
    chk(rdata, 16'h0000);
    access(1, 5'h1a, 16'h00ff);
    access(0, 5'h1b, 0);
    chk(rdata, 16'h0000);
    cont = 1;
    access(1, 5'h1b, 16'h00ff);
    access(0, 5'h1b, 0);
    chk(rdata, 16'h0037);
    chk(prbs, 0);
    run = 1;
    repeat (2) @(negedge clk);
    chk({ipg, prbs}, 16'h0003);
    chk(jab, 0);
    start = 1;
    repeat (3) @(negedge clk);
    errs(5);
    access(0, 5'h1b, 0);
    chk(rdata, 16'h0537);
    run = 0;
    errs(4);
    run = 1;
    access(0, 5'h1b, 0);
    chk(rdata, 16'h0537);
    errs(300);
    access(0, 5'h1b, 0);
    chk(rdata, 16'hff37);
    start = 0;
    @(negedge clk);
    start = 1;
    repeat (3) @(negedge clk);
    access(0, 5'h1b, 0);
    chk(rdata, 16'h0037);
    mode = 1;
    // select is set before enable so outputs never see a stale select
    for (i = 0; i < 4; i = i + 1) begin
        access(1, 5'h1b, i);
        // a stop followed at once by a restart is not a gap; wait it out
        repeat (10) @(negedge clk);
        access(1, 5'h1b, 16'h0010 | i);
        repeat (3) @(negedge clk);
        chk({st, sl, sb, sa}, 16'h1 << i);
        chk(sel, i);
        chk(act, 1);
    end
    access(1, 5'h1b, 16'h0010);
    fire_gap;
    chk(iv >= 1010 && iv <= 1016, 1);
    access(1, 5'h1b, 16'h0014);
    fire_gap;
    fire_gap;
    chk(iv >= 1510 && iv <= 1516, 1);
    access(1, 5'h1b, 16'h0000);
    @(negedge clk);
    chk(act, 0);
    cont = 0;
    repeat (2) @(negedge clk);
    chk(jab, 1);
    end_of_test;
end
endmodule // phy_packet_selftest_pattern_test_ctrl_bench

/* File: verilog/pbtc_ctrl.v */
`timescale 1ns/1ps
`include "pbtc_map.vh"
// Operation
// [R1] count errored receive nibbles during packet self-test in bits 15:8
// [R2] clear the error count whenever packet self-test starts again
// [R3] error count saturates at its maximum, never wraps
// [R4] continuous bit 5 sends pseudo-random data back to back
// [R5] continuous mode acts only while self-test start control is active; code gates it on selftest_run_i instead
// [R6] host sets jabber-disable before continuous self-test at 10 Mb/s
// [R7] pattern-enable bit 4 gates 10 Mb/s test patterns, resets to 0
// [R8] gap bit 2 selects 15 us or 10 us between sequences
// [R9] select field: data seq a, data seq b, link pulses, ones tone
// [R10] register decoded at management address 0x1b, fields reset zero
// [R11] jabber protection off while jabber-disable is 1
// [R12] host writes zero to reserved bits 7, 6 and 3
module pbtc_ctrl #(
    parameter TW = 16
) (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire [4:0] reg_addr_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_wdata_i,
    input wire selftest_start_i,
    input wire selftest_run_i,
    input wire nibble_err_i,
    input wire jabber_disable_i,
    input wire ten_meg_mode_i,
    input wire [TW-1:0] seq_cycles_i,
    output reg [15:0] reg_rdata_o,
    output reg reg_hit_o,
    output reg cont_prbs_tx_o,
    output reg no_ipg_o,
    output reg jabber_enable_o,
    output reg pattern_active_o,
    output reg [1:0] pattern_sel_o,
    output reg seq_data_a_o,
    output reg seq_data_b_o,
    output reg seq_link_o,
    output reg seq_tone_o,
    output reg seq_fire_o
);
    // gap lengths rounded up to whole clocks, then cut to the timer width
    localparam [31:0] GAP_LONG_W =
        (`PBTC_GAP_LONG_NS + `PBTC_CLK_NS - 1) / `PBTC_CLK_NS;
    localparam [31:0] GAP_SHORT_W =
        (`PBTC_GAP_SHORT_NS + `PBTC_CLK_NS - 1) / `PBTC_CLK_NS;
    localparam [TW-1:0] GAP_LONG = GAP_LONG_W[TW-1:0];
    localparam [TW-1:0] GAP_SHORT = GAP_SHORT_W[TW-1:0];
    localparam ST_IDLE = 2'h0;
    localparam ST_SEQ = 2'h1;
    localparam ST_GAP = 2'h2;

    reg [7:0] err_count;
    reg cont_mode;
    reg pat_en;
    reg gap_long;
    reg [1:0] pat_sel;
    reg [2:0] rsvd;
    reg start_d;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [TW-1:0] seq_count;
    reg [15:0] next_rdata;
    reg timer_start;
    wire timer_done;
    wire hit;
    wire restart;

    assign hit = (reg_addr_i == `PBTC_REG_ADDR); // R10
    assign restart = selftest_start_i & ~start_d;

    ////////////////////////////////////////////////////////////////////////
    // register file
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cont_mode <= 1'b0; // R10
            pat_en <= 1'b0; // R7
            gap_long <= 1'b0;
            pat_sel <= `PBTC_SEL_DATA_A;
            rsvd <= 3'h0;
        end else if (reg_wr_i && hit) begin
            cont_mode <= reg_wdata_i[`PBTC_CONT_BIT];
            pat_en <= reg_wdata_i[`PBTC_PATEN_BIT];
            gap_long <= reg_wdata_i[`PBTC_GAP_BIT];
            pat_sel <= reg_wdata_i[`PBTC_SEL_MSB:`PBTC_SEL_LSB];
            // reserved bits are stored so readback shows what was written
            rsvd <= {reg_wdata_i[`PBTC_RSVD_HI], reg_wdata_i[`PBTC_RSVD_LO],
                reg_wdata_i[`PBTC_RSVD_MID]};
        end
    end

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            err_count <= 8'h00;
            start_d <= 1'b0;
        end else begin
            start_d <= selftest_start_i;
            // a restart wins over an error in the same cycle
            if (restart) begin
                err_count <= 8'h00; // R2
            end else if (selftest_run_i && nibble_err_i &&
                err_count != `PBTC_ERR_MAX) begin
                err_count <= err_count + 8'h01; // R1 R3
            end
        end
    end

    always @* begin
        next_rdata = 16'h0000;
        next_rdata[`PBTC_ERR_MSB:`PBTC_ERR_LSB] = err_count; // R1
        next_rdata[`PBTC_RSVD_HI] = rsvd[2];
        next_rdata[`PBTC_RSVD_LO] = rsvd[1];
        next_rdata[`PBTC_CONT_BIT] = cont_mode;
        next_rdata[`PBTC_PATEN_BIT] = pat_en;
        next_rdata[`PBTC_RSVD_MID] = rsvd[0];
        next_rdata[`PBTC_GAP_BIT] = gap_long;
        next_rdata[`PBTC_SEL_MSB:`PBTC_SEL_LSB] = pat_sel;
    end

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 16'h0000;
            reg_hit_o <= 1'b0;
        end else begin
            reg_hit_o <= hit & (reg_rd_i | reg_wr_i);
            if (reg_rd_i && hit) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit controls
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cont_prbs_tx_o <= 1'b0;
            no_ipg_o <= 1'b0;
            jabber_enable_o <= 1'b1;
        end else begin
            cont_prbs_tx_o <= cont_mode & selftest_run_i; // R4 R5
            no_ipg_o <= cont_mode & selftest_run_i; // R4
            // continuous 10 Mb/s sending relies on the host disabling jabber
            jabber_enable_o <= ~jabber_disable_i; // R11 R6
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 10 Mb/s pattern sequencer
    always @* begin
        next_state = state;
        timer_start = 1'b0;
        case (state)
            ST_IDLE: begin
                if (pat_en && ten_meg_mode_i) begin
                    next_state = ST_SEQ; // R7
                end
            end
            ST_SEQ: begin
                if (!pat_en) begin
                    next_state = ST_IDLE;
                end else if (pat_sel == `PBTC_SEL_TONE) begin
                    next_state = ST_SEQ; // tone runs with no gap
                end else if (seq_count == {TW{1'b0}}) begin
                    next_state = ST_GAP;
                    timer_start = 1'b1;
                end
            end
            ST_GAP: begin
                if (!pat_en) begin
                    next_state = ST_IDLE;
                end else if (timer_done) begin
                    next_state = ST_SEQ;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= ST_IDLE;
            seq_count <= {TW{1'b0}};
        end else begin
            state <= next_state;
            if (state != ST_SEQ && next_state == ST_SEQ) begin
                seq_count <= seq_cycles_i;
            end else if (state == ST_SEQ && seq_count != {TW{1'b0}}) begin
                seq_count <= seq_count - {{(TW-1){1'b0}}, 1'b1};
            end
        end
    end

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pattern_active_o <= 1'b0;
            pattern_sel_o <= `PBTC_SEL_DATA_A;
            seq_data_a_o <= 1'b0;
            seq_data_b_o <= 1'b0;
            seq_link_o <= 1'b0;
            seq_tone_o <= 1'b0;
            seq_fire_o <= 1'b0;
        end else begin
            pattern_active_o <= (next_state == ST_SEQ); // R7
            pattern_sel_o <= pat_sel;
            seq_data_a_o <= (next_state == ST_SEQ) &&
                (pat_sel == `PBTC_SEL_DATA_A); // R9
            seq_data_b_o <= (next_state == ST_SEQ) &&
                (pat_sel == `PBTC_SEL_DATA_B); // R9
            seq_link_o <= (next_state == ST_SEQ) &&
                (pat_sel == `PBTC_SEL_LINK); // R9
            seq_tone_o <= (next_state == ST_SEQ) &&
                (pat_sel == `PBTC_SEL_TONE); // R9
            seq_fire_o <= (state != ST_SEQ) && (next_state == ST_SEQ);
        end
    end

    pbtc_gap_timer #(
        .W(TW)
    ) u_gap (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .start_i(timer_start),
        .load_i(gap_long ? GAP_LONG : GAP_SHORT), // R8
        .busy_o(),
        .done_o(timer_done)
    );
endmodule // pbtc_ctrl

/* File: verilog/pbtc_gap_timer.v */
`timescale 1ns/1ps
// counts down one inter-sequence gap, then pulses done_o for one cycle
module pbtc_gap_timer #(
    parameter W = 16
) (
    input wire core_clk_i,
    input wire arst_n_i,
    input wire start_i,
    input wire [W-1:0] load_i,
    output reg busy_o,
    output reg done_o
);
    reg [W-1:0] count;

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count <= {W{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                count <= load_i;
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (count <= {{(W-1){1'b0}}, 1'b1}) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                count <= count - {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // pbtc_gap_timer
